// ==== shared/ducsg_pkg.sv ====
package ducsg_pkg;
  // Register indices (byte address = index * 4)
  localparam logic [7:0] REG_PILOT_SEL  = 8'h0b;
  localparam logic [7:0] REG_GAIN_A     = 8'h0c;
  localparam logic [7:0] REG_GAIN_B     = 8'h0d;
  localparam logic [7:0] REG_FLUSH      = 8'h10;
  localparam logic [7:0] REG_SER_FMT    = 8'h1b;
  localparam logic [7:0] REG_SER_DIV    = 8'h1c;
  localparam logic [7:0] REG_IRQ_STAT   = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h21;
  localparam logic [7:0] REG_OVF_STAT   = 8'h22;

  // Field positions
  localparam int FLD_PILOT_SEL_LSB = 4;
  localparam int FLD_AUTOFL_LSB    = 12;
  localparam int FLD_FTEST_LSB     = 8;
  localparam int FLD_FCLR_LSB      = 4;
  localparam int FLD_BITS_LSB      = 11;
  localparam int FLD_FSDEL_LSB     = 8;
  localparam int FLD_FOURPIN_BIT   = 7;
  localparam int FLD_INTVL_LSB     = 0;

  // Reset values
  localparam logic [15:0] RST_GAIN    = 16'h2000;
  localparam logic [4:0]  RST_BITS    = 5'h11;
  localparam logic [1:0]  RST_FSDEL   = 2'h1;
  localparam logic [6:0]  RST_INTVL   = 7'h32;
  localparam logic [3:0]  RST_CLKDIV  = 4'h1;
  localparam int          GAIN_SHIFT  = 13;

  // Interrupt status bits
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_OVF   = 1;

  // Register port bundle
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ducsg_bus_t;

  // One transmit output bus sample
  typedef struct packed {
    logic [17:0] data;
  } ducsg_out_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_SHIFT = 2'b10,
    ST_GAP   = 2'b11
  } ducsg_state_t;
endpackage

// ==== hdl/ducsg_top.sv ====
module ducsg_top
  import ducsg_pkg::*;
#(
  parameter int NCH   = 12,
  parameter int SBITS = 18
) (
  input  wire logic              clk,          // Transmit clock
  input  wire logic              rst_n,        // Async reset, low
  input  wire ducsg_bus_t        bus,          // Register port
  output logic [15:0]            rdata,        // Read data, next cycle
  output logic                   irq,          // Level interrupt
  input  wire logic [NCH-1:0]    ser_a,        // Lane a serial in
  input  wire logic [NCH-1:0]    ser_b,        // Lane b serial in
  output logic [NCH/2-1:0]       frame_strobe, // Per-pair strobes
  input  wire logic [3:0]        sync_in,      // Sync inputs a..d
  output logic                   sync_out,     // General sync out
  output logic                   clk_out,      // Output bus clock
  output logic [2:0]             pilot_sel,    // Pilot sync source
  output logic [3:0]             flush_dis,    // Auto flush disable
  output logic                   ovf_err,      // Latched overflow
  output ducsg_out_t [3:0]       tx_out        // Output buses
);

  // Register file
  logic [15:0] pilot_ff, gain_a_ff, gain_b_ff, flush_ff, fmt_ff;
  logic [3:0]  div_ff;
  logic [1:0]  stat_ff, mask_ff;
  logic [15:0] nxt_rdata;
  logic        wr_stat, ovf_set, frame_evt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pilot_ff  <= 16'h0000;
      gain_a_ff <= RST_GAIN;
      gain_b_ff <= RST_GAIN;
      flush_ff  <= 16'h0000;
      fmt_ff    <= {RST_BITS, 1'b0, RST_FSDEL, 1'b0, RST_INTVL};
      div_ff    <= RST_CLKDIV;
      mask_ff   <= 2'h0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        REG_PILOT_SEL: pilot_ff  <= bus.wdata;
        REG_GAIN_A:    gain_a_ff <= bus.wdata;
        REG_GAIN_B:    gain_b_ff <= bus.wdata;
        REG_FLUSH:     flush_ff  <= bus.wdata;
        REG_SER_FMT:   fmt_ff    <= bus.wdata;
        REG_SER_DIV:   div_ff    <= bus.wdata[3:0];
        REG_IRQ_MASK:  mask_ff   <= bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  // Field views
  logic [4:0] bits_m1;
  logic [1:0] fsdel;
  logic       four_lane_select;
  logic [6:0] intvl;
  assign bits_m1          = fmt_ff[FLD_BITS_LSB +: 5];
  assign fsdel            = fmt_ff[FLD_FSDEL_LSB +: 2];
  assign four_lane_select = fmt_ff[FLD_FOURPIN_BIT];
  assign intvl            = fmt_ff[FLD_INTVL_LSB +: 7];

  // Read mux, data one cycle later, unmapped reads zero
  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (bus.addr)
      REG_PILOT_SEL: nxt_rdata = pilot_ff;
      REG_GAIN_A:    nxt_rdata = gain_a_ff;
      REG_GAIN_B:    nxt_rdata = gain_b_ff;
      REG_FLUSH:     nxt_rdata = flush_ff;
      REG_SER_FMT:   nxt_rdata = fmt_ff;
      REG_SER_DIV:   nxt_rdata = {12'h000, div_ff};
      REG_IRQ_STAT:  nxt_rdata = {14'h0000, stat_ff};
      REG_IRQ_MASK:  nxt_rdata = {14'h0000, mask_ff};
      REG_OVF_STAT:  nxt_rdata = {15'h0000, ovf_err};
      default:       nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 16'h0000;
    else if (bus.rd) rdata <= nxt_rdata;
    else rdata <= 16'h0000;
  end

  // Pilot selector and flush disable outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pilot_sel <= 3'h0;
      flush_dis <= 4'h0;
    end else begin
      pilot_sel <= pilot_ff[FLD_PILOT_SEL_LSB +: 3];
      flush_dis <= flush_ff[FLD_AUTOFL_LSB +: 4];
    end
  end

  // Overflow test and clear edge detection
  logic [3:0] ftest_q_ff, fclr_q_ff;
  logic       ftest_rise, fclr_rise;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ftest_q_ff <= 4'h0;
      fclr_q_ff  <= 4'h0;
    end else begin
      ftest_q_ff <= flush_ff[FLD_FTEST_LSB +: 4];
      fclr_q_ff  <= flush_ff[FLD_FCLR_LSB +: 4];
    end
  end
  assign ftest_rise = |(flush_ff[FLD_FTEST_LSB +: 4] & ~ftest_q_ff);
  assign fclr_rise  = |(flush_ff[FLD_FCLR_LSB +: 4] & ~fclr_q_ff);
  assign ovf_set    = ftest_rise;

  // Latched overflow: a forced detection wins over a clear edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ovf_err <= 1'b0;
    else if (ovf_set) ovf_err <= 1'b1;
    else if (fclr_rise) ovf_err <= 1'b0;
  end

  // Bit clock enable: transmit clock divided by div+1
  logic [3:0] div_cnt_ff;
  logic       bit_tick;
  assign bit_tick = (div_cnt_ff == 4'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_cnt_ff <= 4'h0;
    else if (bit_tick) div_cnt_ff <= div_ff;
    else div_cnt_ff <= div_cnt_ff - 4'h1;
  end

  // Output clock follows the bit clock phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) clk_out <= 1'b0;
    else if (div_ff == 4'h0) clk_out <= ~clk_out;
    else if (bit_tick) clk_out <= 1'b1;
    // Fall half a bit period after the tick; div of 1 must still toggle
    else if (div_cnt_ff == div_ff - {1'b0, div_ff[3:1]}) clk_out <= 1'b0;
  end

  // Frame sequencer
  ducsg_state_t st_ff;
  logic [6:0]   ivl_cnt_ff;
  logic [1:0]   del_cnt_ff;
  logic [4:0]   bit_cnt_ff;
  logic         strobe_now, shift_en, sample_done, two_pin_phase_ff;

  assign strobe_now = bit_tick && (ivl_cnt_ff == 7'h00);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ivl_cnt_ff <= 7'h00;
    else if (strobe_now) ivl_cnt_ff <= intvl - 7'h01;
    else if (bit_tick && ivl_cnt_ff != 7'h00)
      ivl_cnt_ff <= ivl_cnt_ff - 7'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff      <= ST_IDLE;
      del_cnt_ff <= 2'h0;
      bit_cnt_ff <= 5'h00;
    end else if (strobe_now) begin
      del_cnt_ff <= fsdel;
      bit_cnt_ff <= bits_m1;
      st_ff      <= (fsdel == 2'h0) ? ST_SHIFT : ST_DELAY;
    end else if (bit_tick) begin
      unique case (st_ff)
        ST_IDLE: st_ff <= ST_IDLE;
        ST_DELAY: begin
          if (del_cnt_ff == 2'h1) st_ff <= ST_SHIFT;
          del_cnt_ff <= del_cnt_ff - 2'h1;
        end
        ST_SHIFT: begin
          // In 2-pin mode lane a carries a second word back to back
          if (bit_cnt_ff == 5'h00) begin
            if (!four_lane_select && !two_pin_phase_ff)
              bit_cnt_ff <= bits_m1;
            else
              st_ff <= ST_GAP;
          end else begin
            bit_cnt_ff <= bit_cnt_ff - 5'h01;
          end
        end
        ST_GAP: st_ff <= ST_GAP;
      endcase
    end
  end
  assign shift_en    = bit_tick && (st_ff == ST_SHIFT);
  assign sample_done = shift_en && (bit_cnt_ff == 5'h00);

  // In 2-pin mode lane b is unused: lane a carries A then B words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) two_pin_phase_ff <= 1'b0;
    else if (four_lane_select) two_pin_phase_ff <= 1'b0;
    else if (strobe_now) two_pin_phase_ff <= 1'b0;
    else if (sample_done) two_pin_phase_ff <= ~two_pin_phase_ff;
  end

  // Strobes, one per channel pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) frame_strobe <= '0;
    else frame_strobe <= {(NCH/2){strobe_now}};
  end

  // Per-channel shift registers and sample registers
  logic [NCH-1:0][SBITS-1:0] sh_a_ff, sh_b_ff;
  logic [NCH-1:0][SBITS-1:0] smp_a_ff, smp_b_ff;
  logic [NCH-1:0]            smp_vld;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [SBITS-1:0] nxt_sh_a, nxt_sh_b;
      // MSB first: left shift, new bit in LSB
      assign nxt_sh_a = {sh_a_ff[g][SBITS-2:0], ser_a[g]};
      assign nxt_sh_b = {sh_b_ff[g][SBITS-2:0], ser_b[g]};
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sh_a_ff[g]  <= '0;
          sh_b_ff[g]  <= '0;
          smp_a_ff[g] <= '0;
          smp_b_ff[g] <= '0;
        end else begin
          if (shift_en) begin
            sh_a_ff[g] <= nxt_sh_a;
            sh_b_ff[g] <= nxt_sh_b;
          end
          if (sample_done && (four_lane_select || !two_pin_phase_ff))
            smp_a_ff[g] <= nxt_sh_a;
          if (sample_done && four_lane_select)
            smp_b_ff[g] <= nxt_sh_b;
          else if (sample_done && two_pin_phase_ff)
            smp_b_ff[g] <= nxt_sh_a;
        end
      end
      assign smp_vld[g] = sample_done;
    end
  endgenerate

  // Scaled sum of A on bus a and B on bus b; buses c/d carry channel 0 A and B unscaled
  logic signed [SBITS+17:0] acc_a, acc_b;
  always_comb begin
    acc_a = '0;
    acc_b = '0;
    for (int i = 0; i < NCH; i++) begin
      acc_a = acc_a + ($signed(smp_a_ff[i]) * $signed({1'b0, gain_a_ff}));
      acc_b = acc_b + ($signed(smp_b_ff[i]) * $signed({1'b0, gain_b_ff}));
    end
  end

  // Output buses, bit 17 most significant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out <= '0;
    end else if (smp_vld[0]) begin
      tx_out[0].data <= acc_a[GAIN_SHIFT +: 18];
      tx_out[1].data <= acc_b[GAIN_SHIFT +: 18];
      tx_out[2].data <= smp_a_ff[0][SBITS-1 -: 18];
      tx_out[3].data <= smp_b_ff[0][SBITS-1 -: 18];
    end
  end

  // General sync out: any sync input, retimed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sync_out <= 1'b0;
    else sync_out <= |sync_in;
  end

  // Interrupt status: set wins over write-one-to-clear
  assign frame_evt = strobe_now;
  assign wr_stat   = bus.wr && (bus.addr == REG_IRQ_STAT);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stat_ff <= 2'h0;
    else begin
      stat_ff[IRQ_FRAME] <= frame_evt ||
        (stat_ff[IRQ_FRAME] && !(wr_stat && bus.wdata[IRQ_FRAME]));
      stat_ff[IRQ_OVF] <= ovf_set ||
        (stat_ff[IRQ_OVF] && !(wr_stat && bus.wdata[IRQ_OVF]));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else irq <= |(stat_ff & mask_ff);
  end

endmodule

// ==== dv/ducsg_props.sv ====
module ducsg_props
  import ducsg_pkg::*;
#(
  parameter int NCH = 12
) (
  input wire logic           clk,          // Transmit clock
  input wire logic           rst_n,        // Async reset, low
  input wire ducsg_bus_t     bus,          // Register port
  input wire logic [15:0]    rdata,        // Read data
  input wire logic [NCH/2-1:0] frame_strobe, // Pair strobes
  input wire logic [3:0]     sync_in,      // Sync inputs
  input wire logic           sync_out,     // Sync output
  input wire logic [2:0]     pilot_sel,    // Pilot source
  input wire logic [3:0]     flush_dis,    // Flush disable
  input wire logic           ovf_err,      // Latched overflow
  input wire logic           clk_out       // Output bus clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fwr;
  // Write to the flush control register
  assign fwr = bus.wr && bus.addr == REG_FLUSH;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Register write steps
  sequence s_pwr;
    bus.wr && bus.addr == REG_PILOT_SEL;
  endsequence
  sequence s_fwr;
    bus.wr && bus.addr == REG_FLUSH;
  endsequence
  a_pilot_copy: assert property (s_pwr |-> ##2 pilot_sel == $past(bus.wdata[6:4], 2))
    else $error("pilot selector not taken from write");
  a_flush_copy: assert property (s_fwr |-> ##2 flush_dis == $past(bus.wdata[15:12], 2))
    else $error("flush disable not taken from write");
  a_clk_out_live: assert property (1'b1 |-> ##[1:16] $changed(clk_out))
    else $error("output clock stopped");
  a_strobe_pulse: assert property ($rose(frame_strobe[0]) |=> !frame_strobe[0])
    else $error("frame strobe longer than one clock");
  a_strobe_pairs: assert property (frame_strobe == {(NCH/2){frame_strobe[0]}})
    else $error("pair strobes differ");
  a_sync_out: assert property (sync_out == $past(|sync_in))
    else $error("sync output not OR of inputs");
  a_ovf_rise: assert property ($rose(ovf_err) |-> $past(fwr) || $past(fwr, 2) || $past(fwr, 3))
    else $error("overflow set without test write");
  a_ovf_fall: assert property ($fell(ovf_err) |-> $past(fwr) || $past(fwr, 2) || $past(fwr, 3))
    else $error("overflow cleared without clear write");
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0)
    else $error("read data outside answer cycle");
endmodule

bind ducsg_top ducsg_props #(.NCH(NCH)) u_props (.clk(clk), .rst_n(rst_n),
  .bus(bus), .rdata(rdata), .frame_strobe(frame_strobe), .sync_in(sync_in),
  .sync_out(sync_out), .pilot_sel(pilot_sel), .flush_dis(flush_dis),
  .ovf_err(ovf_err), .clk_out(clk_out));

// ==== dv/ducsg_source.sv ====
module ducsg_source
  import ducsg_pkg::*;
#(
  parameter int NCH = 12
) (
  input wire logic           clk,   // Transmit clock
  input wire logic           rst_n, // Async reset, low
  input wire logic           stb,   // Frame strobe
  input wire logic [3:0]     div,   // Bit clock divider
  input wire logic [1:0]     dly,   // Strobe to MSB delay
  input wire logic           four,  // Four lane mode
  input wire logic [17:0]    sa,    // Lane a sample
  input wire logic [17:0]    sb,    // Lane b sample
  output logic [NCH-1:0]     ser_a, // Lane a serial out
  output logic [NCH-1:0]     ser_b  // Lane b serial out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cnt_ff;
  logic [35:0] w;
  int          i;
  // Cycles since the last strobe, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 12'hfff;
    else if (stb) cnt_ff <= 12'h1;
    else if (cnt_ff != 12'hfff) cnt_ff <= cnt_ff + 12'h1;
  end
  // Bit index held up to the sampling tick, MSB preloaded when idle
  always_comb begin
    i = (stb ? 0 : int'(cnt_ff)) / (int'(div) + 1) - int'(dly);
    if (!stb && cnt_ff == 12'hfff) i = -1;
    w = four ? {sa, 18'h0} : {sa, sb};
    ser_a = {NCH{(i >= 0 && i < (four ? 18 : 36)) ? w[35-i] : w[35]}};
    ser_b = {NCH{four ? ((i >= 0 && i < 18) ? sb[17-i] : sb[17]) : cnt_ff[0]}};
  end
endmodule

// ==== dv/ducsg_top_bench.sv ====
module ducsg_top_bench
  import ducsg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 0, rst_n = 0, go = 0, irq, sync_out, clk_out, ovf_err;
  ducsg_bus_t       bus = '0;
  logic [15:0]      rdata;
  logic [11:0]      ser_a, ser_b;
  logic [5:0]       frame_strobe;
  logic [3:0]       sync_in = 0, flush_dis, div = 1;
  logic [2:0]       pilot_sel;
  logic [1:0]       dly = 1;
  logic             four = 0;
  logic [17:0]      sa = 0, sb = 0;
  ducsg_out_t [3:0] tx_out;
  int               errors = 0, checked = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (go) sync_in <= 4'($urandom);
  ducsg_top uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .irq(irq), .ser_a(ser_a), .ser_b(ser_b), .frame_strobe(frame_strobe),
    .sync_in(sync_in), .sync_out(sync_out), .clk_out(clk_out),
    .pilot_sel(pilot_sel), .flush_dis(flush_dis), .ovf_err(ovf_err),
    .tx_out(tx_out));
  ducsg_source src (.clk(clk), .rst_n(rst_n), .stb(frame_strobe[0]),
    .div(div), .dly(dly), .four(four), .sa(sa), .sb(sb), .ser_a(ser_a),
    .ser_b(ser_b));
  // Twelve equal channels scaled by gain over 8192
  function automatic logic [17:0] gsum(logic [17:0] s, logic [15:0] g);
    logic signed [39:0] p;
    p = $signed(s) * $signed({1'b0, g}) * 12;
    return p[30:13];
  endfunction
  task automatic chk(logic [17:0] got, logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] d);
    @(posedge clk) bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 d = rdata;
  endtask
  task automatic wstb(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (frame_strobe[0] !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      errors++;
      $display("BAD %0t no frame strobe", $time);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #900000;
    errors++;
    summarize;
  end
  initial begin
    logic [15:0] d, ga, gb;
    logic [9:0]  r;
    logic [6:0]  iv;
    int          n;
    void'($urandom(32'h6b8d));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    rd(REG_GAIN_A, d); chk(18'(d), 18'h2000);
    rd(REG_GAIN_B, d); chk(18'(d), 18'h2000);
    rd(REG_SER_FMT, d); chk(18'(d), 18'h8932);
    rd(REG_SER_DIV, d); chk(18'(d), 18'h1);
    rd(REG_PILOT_SEL, d); chk(18'(d), 18'h0);
    rd(REG_FLUSH, d); chk(18'(d), 18'h0);
    rd(8'h05, d); chk(18'(d), 18'h0);
    go <= 1;
    wstb(n); wstb(n); chk(18'(n), 18'd100);
    wr(REG_PILOT_SEL, 16'h0070);
    repeat (2) @(negedge clk);
    chk(18'(pilot_sel), 18'h7);
    // Delays, lane modes and dividers with random gains and samples
    for (int t = 0; t < 8; t++) begin
      dly = t[1:0];
      four = t[2];
      div = (t == 7) ? 4'hf : 4'($urandom_range(0, 3));
      iv = 7'($urandom_range(40, 60));
      ga = (t == 0) ? 16'h2000 : 16'($urandom);
      gb = 16'($urandom);
      r = 10'($urandom);
      sa = {{8{r[9]}}, r};
      r = 10'($urandom);
      sb = {{8{r[9]}}, r};
      wr(REG_GAIN_A, ga);
      wr(REG_GAIN_B, gb);
      wr(REG_SER_DIV, {12'h0, div});
      wr(REG_SER_FMT, {5'h11, 1'b0, dly, four, iv});
      wstb(n); wstb(n); wstb(n);
      chk(18'(n), 18'(iv) * (18'(div) + 18'd1));
      chk(tx_out[0].data, gsum(sa, ga));
      chk(tx_out[1].data, gsum(sb, gb));
      chk(tx_out[2].data, sa);
      chk(tx_out[3].data, sb);
    end
    // Frame interrupt raised, masked and cleared
    wr(REG_IRQ_MASK, 16'h0001);
    wstb(n);
    repeat (3) @(negedge clk);
    chk(18'(irq), 18'h1);
    rd(REG_IRQ_STAT, d); chk(18'(d[0]), 18'h1);
    wr(REG_IRQ_MASK, 16'h0000);
    repeat (2) @(negedge clk);
    chk(18'(irq), 18'h0);
    wstb(n);
    wr(REG_IRQ_STAT, 16'h0001);
    rd(REG_IRQ_STAT, d); chk(18'(d[0]), 18'h0);
    // Overflow force and clear act on rising edges only
    wr(REG_FLUSH, 16'ha000);
    repeat (2) @(negedge clk);
    chk(18'(flush_dis), 18'ha);
    wr(REG_FLUSH, 16'h0f00);
    repeat (3) @(negedge clk);
    chk(18'(ovf_err), 18'h1);
    rd(REG_OVF_STAT, d); chk(18'(d[0]), 18'h1);
    wr(REG_FLUSH, 16'h0ff0);
    repeat (3) @(negedge clk);
    chk(18'(ovf_err), 18'h0);
    wr(REG_FLUSH, 16'h00f0);
    wr(REG_FLUSH, 16'h0ff0);
    repeat (3) @(negedge clk);
    chk(18'(ovf_err), 18'h1);
    summarize;
  end
endmodule
